// [core/io_port_pkg.sv]
// Package for the general-purpose port, infrared and pulse-width block.
// Assumes a 100 MHz bus clock and an AXI4-Lite master with 8-bit addresses.
package io_port_pkg;

  // Clocking and derived counts
  localparam int CLK_HZ        = 100_000_000;
  localparam int SYS_HZ        = 2_000_000;
  localparam int INSTR_NS      = 4_000;
  localparam int IR_CARRIER_HZ = 38_500;
  localparam int SYS_DIV       = CLK_HZ / SYS_HZ;
  localparam int IR_HALF       = (SYS_HZ + IR_CARRIER_HZ) / (2 * IR_CARRIER_HZ);

  // Pin layout: port a [3:0], b [7:4], c [11:8], d [15:12]
  localparam int PORTS      = 4;
  localparam int PORT_W     = 4;
  localparam int PINS       = PORTS * PORT_W;
  localparam int PWM_W      = 8;
  localparam int PORT_C_LSB = 8;
  localparam int PIN_IR     = 11;
  localparam int PIN_IR_ALT = 7;

  // Register byte addresses
  localparam logic [7:0] ADDR_DIR   = 8'h00;
  localparam logic [7:0] ADDR_OUT   = 8'h04;
  localparam logic [7:0] ADDR_IN    = 8'h08;
  localparam logic [7:0] ADDR_MODE  = 8'h0c;
  localparam logic [7:0] ADDR_MODE1 = 8'h10;
  localparam logic [7:0] ADDR_PWMEN = 8'h14;
  localparam logic [7:0] ADDR_DUTY  = 8'h18;
  localparam logic [7:0] ADDR_CTRL  = 8'h1c;

  // Field positions
  localparam int MODE_IR_EN_BIT = 3;
  localparam int MODE1_SEL_BIT  = 1;
  localparam int CTRL_STOP_BIT  = 0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {PWR_RUN, PWR_STOP} pwr_e;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

  typedef struct packed {
    axi_rsp_s          rsp;
    logic              aw_full;
    logic [7:0]        aw_addr;
    logic              w_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic [PINS-1:0]   dir;
    logic [PINS-1:0]   dout;
    logic [3:0]        mode;
    logic [3:0]        mode1;
    logic [PORT_W-1:0] pwm_en;
    logic [31:0]       duty;
    pwr_e              power;
    logic              run;
    logic [5:0]        div_cnt;
    logic [4:0]        ir_cnt;
    logic              carrier;
    logic [PWM_W-1:0]  pwm_cnt;
    logic [PINS-1:0]   pin_sync1;
    logic [PINS-1:0]   pin_sync2;
    logic [PINS-1:0]   pin_last;
    logic              rst_sync1;
    logic              rst_sync2;
    logic [PINS-1:0]   pad_out;
    logic [PINS-1:0]   pad_oe;
    logic [PINS-1:0]   pull_en;
  } io_state_s;

endpackage

// [core/io_port_ir_pwm_wakeup.sv]
// Four 4-bit ports with pull-low inputs, infrared carrier, port c pulse-width
// outputs and stop-mode wake-up, all under an AXI4-Lite register slave.
// Assumes pads resolve level from pad_out/pad_oe and pull_en outside.
//
// Contract
// - Four 4-bit ports, each pin input-pulldown or output
// - Stop command halts system clock until wake
// - Any pin edge while stopped restarts clock
// - Mode bit 3 enables infrared function
// - Port c bit 3 gated by 38.5 kHz carrier
// - Select bit routes infrared to b3 or c3
// - Port c pins have own 8-bit duty
// - 2 MHz system tick drives carrier and pulse-width
// - Active-high chip reset clears port, infrared, pulse-width
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module io_port_ir_pwm_wakeup (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    chip_rst,
  // Register bus
  input  wire io_port_pkg::axi_req_s   axi_req,
  output var  io_port_pkg::axi_rsp_s   axi_rsp,
  // Pins
  input  wire logic [io_port_pkg::PINS-1:0] pad_in,
  output logic [io_port_pkg::PINS-1:0]      pad_out,
  output logic [io_port_pkg::PINS-1:0]      pad_oe,
  output logic [io_port_pkg::PINS-1:0]      pull_en,
  // System clock gate toward the core
  output logic                         clk_run
);
  import io_port_pkg::*;

  io_state_s st;
  io_state_s nx;
  logic      do_write;
  logic      sys_tick;
  logic      wake;
  logic      ir_sig;
  logic      ir_on;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ADDR_DIR) || (a == ADDR_OUT) || (a == ADDR_IN) || (a == ADDR_MODE)
           || (a == ADDR_MODE1) || (a == ADDR_PWMEN) || (a == ADDR_DUTY) || (a == ADDR_CTRL);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    merge = m;
  endfunction

  function automatic logic [31:0] read_reg(input io_state_s s, input logic [7:0] a);
    case (a)
      ADDR_DIR:   read_reg = {16'h0000, s.dir};
      ADDR_OUT:   read_reg = {16'h0000, s.dout};
      ADDR_IN:    read_reg = {16'h0000, s.pin_sync2};
      ADDR_MODE:  read_reg = {28'h0000000, s.mode};
      ADDR_MODE1: read_reg = {28'h0000000, s.mode1};
      ADDR_PWMEN: read_reg = {28'h0000000, s.pwm_en};
      ADDR_DUTY:  read_reg = s.duty;
      ADDR_CTRL:  read_reg = {31'h00000000, s.power == PWR_STOP};
      default:    read_reg = 32'h00000000;
    endcase
  endfunction

  // Lane is high while the period counter is below its duty
  function automatic logic pwm_high(input logic [PWM_W-1:0] cnt, input logic [31:0] d,
                                    input int lane);
    pwm_high = cnt < d[lane*PWM_W +: PWM_W];
  endfunction

  // Derived system tick, halted in stop mode
  assign sys_tick = (st.div_cnt == 6'(SYS_DIV - 1)) && (st.power == PWR_RUN);
  assign wake     = (st.power == PWR_STOP) && (st.pin_sync2 != st.pin_last);
  assign do_write = st.aw_full && st.w_full && !st.rsp.bvalid;
  assign ir_on    = st.mode[MODE_IR_EN_BIT];
  assign ir_sig   = st.dout[PIN_IR] & st.carrier;

  always_comb begin
    logic [PINS-1:0] drv;
    logic [31:0]     wv;
    drv = st.dout;
    wv  = merge(read_reg(st, st.aw_addr), st.w_data, st.w_strb);
    nx  = st;
    nx.rst_sync1 = chip_rst;
    nx.rst_sync2 = st.rst_sync1;
    nx.pin_sync1 = pad_in;
    nx.pin_sync2 = st.pin_sync1;
    nx.pin_last  = st.pin_sync2;

    // Write address and data may arrive in either order
    if (axi_req.awvalid && st.rsp.awready) begin
      nx.aw_full = 1'b1;
      nx.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st.rsp.wready) begin
      nx.w_full = 1'b1;
      nx.w_data = axi_req.wdata;
      nx.w_strb = axi_req.wstrb;
    end
    if (axi_req.bready && st.rsp.bvalid) begin
      nx.rsp.bvalid = 1'b0;
    end
    if (do_write) begin
      nx.aw_full       = 1'b0;
      nx.w_full        = 1'b0;
      nx.rsp.bvalid    = 1'b1;
      nx.rsp.bresp     = addr_ok(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (st.aw_addr)
        ADDR_DIR:   nx.dir    = wv[PINS-1:0];
        ADDR_OUT:   nx.dout   = wv[PINS-1:0];
        ADDR_MODE:  nx.mode   = wv[3:0];
        ADDR_MODE1: nx.mode1  = wv[3:0];
        ADDR_PWMEN: nx.pwm_en = wv[PORT_W-1:0];
        ADDR_DUTY:  nx.duty   = wv;
        ADDR_CTRL: begin
          if (st.w_strb[0] && st.w_data[CTRL_STOP_BIT]) begin
            nx.power = PWR_STOP;
          end
        end
        default: ;
      endcase
    end
    nx.rsp.awready = !nx.aw_full && !nx.rsp.bvalid;
    nx.rsp.wready  = !nx.w_full && !nx.rsp.bvalid;

    // Read channel: one read at a time
    if (axi_req.rready && st.rsp.rvalid) begin
      nx.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st.rsp.arready) begin
      nx.rsp.rvalid = 1'b1;
      nx.rsp.rdata  = read_reg(st, axi_req.araddr);
      nx.rsp.rresp  = addr_ok(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    nx.rsp.arready = !nx.rsp.rvalid;

    // Wake from stop on any synchronized pin edge
    if (wake) begin
      nx.power = PWR_RUN;
    end
    nx.run = (nx.power == PWR_RUN);

    // System tick divider, carrier and pulse-width counter
    if (st.power == PWR_RUN) begin
      nx.div_cnt = sys_tick ? 6'h00 : st.div_cnt + 6'h01;
    end
    if (sys_tick) begin
      nx.pwm_cnt = st.pwm_cnt + 8'h01;
      if (st.ir_cnt == 5'(IR_HALF - 1)) begin
        nx.ir_cnt  = 5'h00;
        nx.carrier = !st.carrier;
      end else begin
        nx.ir_cnt = st.ir_cnt + 5'h01;
      end
    end

    // Pin drive: pulse-width on port c, infrared overrides its target pin
    for (int i = 0; i < PORT_W; i++) begin
      if (st.pwm_en[i]) begin
        drv[PORT_C_LSB + i] = pwm_high(st.pwm_cnt, st.duty, i);
      end
    end
    if (ir_on) begin
      if (st.mode1[MODE1_SEL_BIT]) begin
        drv[PIN_IR_ALT] = ir_sig;
      end else begin
        drv[PIN_IR] = ir_sig;
      end
    end
    nx.pad_out = drv;
    nx.pad_oe  = st.dir;
    nx.pull_en = ~st.dir;

    // Chip reset pin clears port, infrared and pulse-width state
    if (st.rst_sync2) begin
      nx.dir     = '0;
      nx.dout    = '0;
      nx.mode    = '0;
      nx.mode1   = '0;
      nx.pwm_en  = '0;
      nx.duty    = '0;
      nx.power   = PWR_RUN;
      nx.run     = 1'b1;
      nx.div_cnt = '0;
      nx.ir_cnt  = '0;
      nx.carrier = 1'b0;
      nx.pwm_cnt = '0;
      nx.pad_out = '0;
      nx.pad_oe  = '0;
      nx.pull_en = '1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign axi_rsp = st.rsp;
  assign pad_out = st.pad_out;
  assign pad_oe  = st.pad_oe;
  assign pull_en = st.pull_en;
  assign clk_run = st.run;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Direction, pull-down and input sampling
  pin_oe_follow_a: assert property (!st.rst_sync2
      |=> pad_oe == $past(st.dir) && pull_en == ~pad_oe)
    else $error("pad enable does not follow direction");
  in_sync_a: assert property (axi_req.arvalid && st.rsp.arready
      && axi_req.araddr == ADDR_IN |=> axi_rsp.rdata == {16'h0000, $past(st.pin_sync2)})
    else $error("input register does not show synced pins");

  // Stop and wake-up
  stop_enter_a: assert property (do_write && st.aw_addr == ADDR_CTRL && st.w_strb[0]
      && st.w_data[CTRL_STOP_BIT] && !wake && !st.rst_sync2 |=> !clk_run && !sys_tick)
    else $error("stop command did not halt the clock");
  stop_hold_a: assert property (st.power == PWR_STOP && !wake && !st.rst_sync2
      |=> st.power == PWR_STOP && $stable(st.pwm_cnt))
    else $error("clock ran while stopped");
  stop_read_a: assert property (axi_req.arvalid && st.rsp.arready
      && axi_req.araddr == ADDR_CTRL |=> axi_rsp.rdata[0] == ($past(st.power) == PWR_STOP))
    else $error("control register does not show stop state");
  wake_up_a: assert property (wake |=> clk_run && st.power == PWR_RUN)
    else $error("pin edge did not wake the device");

  // Infrared enable, gating and routing
  ir_disabled_a: assert property (!ir_on && st.pwm_en[3] == 1'b0 && !st.rst_sync2
      |=> pad_out[PIN_IR] == $past(st.dout[PIN_IR]))
    else $error("infrared gating while disabled");
  ir_gate_a: assert property (ir_on && !st.mode1[MODE1_SEL_BIT] && !st.carrier
      && !st.rst_sync2 |=> !pad_out[PIN_IR])
    else $error("carrier low but infrared pin high");
  ir_main_a: assert property (ir_on && !st.mode1[MODE1_SEL_BIT] && !st.rst_sync2
      |=> pad_out[PIN_IR] == $past(ir_sig))
    else $error("infrared not on main pin");
  ir_route_a: assert property (ir_on && st.mode1[MODE1_SEL_BIT] && !st.rst_sync2
      |=> pad_out[PIN_IR_ALT] == $past(ir_sig))
    else $error("infrared not routed to alternate pin");
  ir_keep_a: assert property (ir_on && st.mode1[MODE1_SEL_BIT] && !st.pwm_en[3]
      && !st.rst_sync2 |=> pad_out[PIN_IR] == $past(st.dout[PIN_IR]))
    else $error("main pin lost its output while infrared routed away");
  carrier_flip_a: assert property (sys_tick && st.ir_cnt == 5'(IR_HALF - 1)
      && !st.rst_sync2 |=> st.carrier != $past(st.carrier))
    else $error("carrier did not toggle at half period");

  // System tick and pulse-width
  tick_div_a: assert property (st.div_cnt < 6'(SYS_DIV))
    else $error("system divider out of range");
  tick_gap_a: assert property (sys_tick |=> (!sys_tick) [*8])
    else $error("system ticks too close together");
  tick_hold_a: assert property (!sys_tick && !st.rst_sync2
      |=> $stable(st.carrier) && $stable(st.pwm_cnt))
    else $error("carrier or pulse-width moved without a tick");
  pwm_duty_a: assert property (st.pwm_en[0] && !st.rst_sync2
      |=> pad_out[PORT_C_LSB] == ($past(st.pwm_cnt) < $past(st.duty[7:0])))
    else $error("pulse-width pin disagrees with duty");
  pwm_lane_a: assert property (st.pwm_en[1] && !st.rst_sync2
      |=> pad_out[PORT_C_LSB + 1] == pwm_high($past(st.pwm_cnt), $past(st.duty), 1))
    else $error("second pulse-width lane disagrees with duty");
  pwm_third_a: assert property (st.pwm_en[2] && !st.rst_sync2
      |=> pad_out[PORT_C_LSB + 2] == pwm_high($past(st.pwm_cnt), $past(st.duty), 2))
    else $error("third pulse-width lane disagrees with duty");
  pwm_top_a: assert property (st.pwm_en[3] && !ir_on && !st.rst_sync2
      |=> pad_out[PIN_IR] == pwm_high($past(st.pwm_cnt), $past(st.duty), 3))
    else $error("top pulse-width lane disagrees with duty");
  pwm_wrap_a: assert property (sys_tick && st.pwm_cnt == 8'hff && !st.rst_sync2
      |=> st.pwm_cnt == 8'h00)
    else $error("pulse-width period is not 256 counts");
  pwm_step_a: assert property (sys_tick && !st.rst_sync2
      |=> st.pwm_cnt == $past(st.pwm_cnt) + 8'h01)
    else $error("pulse-width counter did not step on a tick");

  // Chip reset
  chip_reset_a: assert property (st.rst_sync2 |=> st.dir == '0 && st.duty == '0
      && st.mode == '0 && clk_run)
    else $error("chip reset did not clear state");
  pads_reset_a: assert property (st.rst_sync2
      |=> pad_oe == '0 && pad_out == '0 && pull_en == '1 && st.pwm_cnt == '0 && !st.carrier)
    else $error("chip reset did not release the pads");

  stop_wake_c: cover property (st.power == PWR_STOP ##[1:20] wake);
  ir_alt_c: cover property (ir_on && st.mode1[MODE1_SEL_BIT] && st.carrier);
  pwm_run_c: cover property (st.pwm_en[3] && pad_out[PIN_IR]);
  write_done_c: cover property (st.rsp.bvalid && axi_req.bready);
  chip_reset_c: cover property (st.rst_sync2 && st.pwm_en != '0);

endmodule

`default_nettype wire

// [verification/pin_model.sv]
// Far side of the port pins: keys that may drive a pin, loads that only listen.
// Assumes the bench sets key drive per pin; the device's own drive always wins.
`timescale 1ns/1ns
`default_nettype none

module pin_model (
  // Device side
  input  wire logic [io_port_pkg::PINS-1:0] pad_out,
  input  wire logic [io_port_pkg::PINS-1:0] pad_oe,
  input  wire logic [io_port_pkg::PINS-1:0] pull_en,
  // Keys
  input  wire logic [io_port_pkg::PINS-1:0] key_oe,
  input  wire logic [io_port_pkg::PINS-1:0] key_val,
  // Resolved level
  output logic      [io_port_pkg::PINS-1:0] pad_in
);
  import io_port_pkg::*;

  // Undriven pin settles low by pull-down, else reads the inverse of pad_out
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (key_oe[i]) pad_in[i] = key_val[i];
      else if (pull_en[i]) pad_in[i] = 1'b0;
      else pad_in[i] = ~pad_out[i];
    end
  end
endmodule

`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the port, infrared, pulse-width and wake-up block.
// Assumes the pin model on the pads; bus answers are checked from queues.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import io_port_pkg::*;

  logic clk, rst_n, chip_rst, clk_run;
  axi_req_s req;
  axi_rsp_s rsp;
  logic [PINS-1:0] pad_in, pad_out, pad_oe, pull_en, key_oe, key_val, dir, out;
  int n_errors, total_checks, n;
  int h[PINS];
  logic [33:0] rq[$];
  logic [1:0] wq[$];
  logic [31:0] duty;
  logic [3:0] strb;

  io_port_ir_pwm_wakeup uut (.clk(clk), .rst_n(rst_n), .chip_rst(chip_rst), .axi_req(req),
    .axi_rsp(rsp), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pull_en(pull_en),
    .clk_run(clk_run));
  pin_model pins (.pad_out(pad_out), .pad_oe(pad_oe), .pull_en(pull_en), .key_oe(key_oe),
    .key_val(key_val), .pad_in(pad_in));

  always #5 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    n_errors++;
    stop_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    wq.push_back(r);
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= strb;
    req.bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
    if (k == 100) hang();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    rq.push_back({r, d});
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    req.rready <= 1'b0;
    if (k == 100) hang();
  endtask

  // Counts the cycles each pin is high over a window
  task automatic cnt(input int cycles);
    foreach (h[i]) h[i] = 0;
    repeat (cycles) begin
      @(posedge clk);
      foreach (h[i]) h[i] += int'(pad_out[i]);
    end
  endtask

  // Answer monitor: oldest expectation against each completed response
  always @(posedge clk) begin
    if (rsp.rvalid && req.rready) check({rsp.rresp, rsp.rdata}, rq.pop_front());
    if (rsp.bvalid && req.bready) check({32'h0, rsp.bresp}, {32'h0, wq.pop_front()});
  end

  initial begin
    #1_000_000;
    hang();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    chip_rst = 1'b0;
    req = '0;
    strb = 4'hf;
    key_oe = '0;
    key_val = '0;
    void'($urandom(97));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check({pull_en, pad_oe, 1'b0, clk_run}, {16'hffff, 16'h0, 2'b01});
    rd(ADDR_DIR, 32'h0, RESP_OKAY);
    for (int t = 0; t < 3; t++) begin
      dir = 16'($urandom);
      out = 16'($urandom);
      key_oe <= 16'($urandom);
      key_val <= 16'($urandom);
      wr(ADDR_DIR, {16'h0, dir}, RESP_OKAY);
      wr(ADDR_OUT, {16'h0, out}, RESP_OKAY);
      repeat (4) @(posedge clk);
      check({2'b0, pad_oe, ~pull_en}, {2'b0, dir, dir});
      check({18'h0, pad_out & dir}, {18'h0, out & dir});
      rd(ADDR_IN, {16'h0, (dir & out) | (~dir & key_oe & key_val)}, RESP_OKAY);
    end
    wr(8'h20, 32'h1, RESP_SLVERR);
    rd(8'h20, 32'h0, RESP_SLVERR);
    // Stop, stay stopped, then wake on a key edge
    wr(ADDR_DIR, 32'h0, RESP_OKAY);
    key_oe <= 16'h0001;
    key_val <= 16'h0;
    repeat (6) @(posedge clk);
    wr(ADDR_CTRL, 32'h1 << CTRL_STOP_BIT, RESP_OKAY);
    repeat (100) @(posedge clk);
    check({33'h0, clk_run}, 34'h0);
    rd(ADDR_CTRL, 32'h1, RESP_OKAY);
    key_val <= 16'h0001;
    for (n = 0; n < 20 && clk_run !== 1'b1; n++) @(posedge clk);
    check({33'h0, clk_run}, 34'h1);
    // Infrared carrier on either pin, then disabled
    wr(ADDR_DIR, 32'hffff, RESP_OKAY);
    wr(ADDR_OUT, 32'h0880, RESP_OKAY);
    wr(ADDR_MODE, 32'h1 << MODE_IR_EN_BIT, RESP_OKAY);
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_MODE1, 32'(s) << MODE1_SEL_BIT, RESP_OKAY);
      repeat (10) @(posedge clk);
      cnt(4 * IR_HALF * SYS_DIV);
      check(34'(s ? h[PIN_IR_ALT] : h[PIN_IR]), 34'(2 * IR_HALF * SYS_DIV));
      check(34'(s ? h[PIN_IR] : h[PIN_IR_ALT]), 34'(4 * IR_HALF * SYS_DIV));
    end
    wr(ADDR_MODE, 32'h0, RESP_OKAY);
    repeat (10) @(posedge clk);
    cnt(3000);
    check(34'(h[PIN_IR] + h[PIN_IR_ALT]), 34'd6000);
    // Pulse width on all four port c pins, boundary duties at both ends
    duty = {8'hff, 8'($urandom), 8'($urandom), 8'h00};
    wr(ADDR_DUTY, duty, RESP_OKAY);
    wr(ADDR_PWMEN, 32'hf, RESP_OKAY);
    repeat (10) @(posedge clk);
    cnt(256 * SYS_DIV);
    for (int i = 0; i < PORT_W; i++)
      check(34'(h[PORT_C_LSB + i]), 34'(int'(duty[8*i +: 8]) * SYS_DIV));
    // One byte lane written, the other duty lanes kept
    strb = 4'h2;
    wr(ADDR_DUTY, 32'h5a5a5a5a, RESP_OKAY);
    strb = 4'hf;
    rd(ADDR_DUTY, {duty[31:16], 8'h5a, duty[7:0]}, RESP_OKAY);
    // Chip reset clears ports and pulse-width state
    chip_rst <= 1'b1;
    repeat (2) @(posedge clk);
    chip_rst <= 1'b0;
    repeat (6) @(posedge clk);
    check({pull_en, pad_oe, 1'b0, clk_run}, {16'hffff, 16'h0, 2'b01});
    check({18'h0, pad_out}, 34'h0);
    rd(ADDR_DUTY, 32'h0, RESP_OKAY);
    rd(ADDR_PWMEN, 32'h0, RESP_OKAY);
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule

`default_nettype wire
